// ==== core/bridge_system_setup.sv ====
`timescale 1ns/1ps
`include "bridge_setup_map.svh"
// middle slice of the bridge system setup register, two card-bus functions
module bridge_system_setup #(
  parameter int SETTLE_UP = `SETTLE_UP_CYC,
  parameter int SETTLE_DN = `SETTLE_DN_CYC
) (
  // clock and resets; rstn is the global reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic bus_reset_n,
  input wire logic pme_en,
  // configuration access
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // socket side
  input wire bridge_setup_pkg::sock_vec_t card_present,
  input wire bridge_setup_pkg::sock_vec_t socket_access,
  input wire bridge_setup_pkg::sock_vec_t probe_active,
  output bridge_setup_pkg::sock_vec_t rsvd_pin_out,
  output bridge_setup_pkg::sock_vec_t rsvd_pin_oe,
  // power switch side
  input wire logic pwr_change_req,
  input wire logic pwr_up,
  input wire logic stream_shift_done,
  // control levels to the rest of the bridge
  output bridge_setup_pkg::sock_vec_t supply_guard_disable,
  output logic read_burst_down_en,
  output logic read_burst_up_en,
  output logic low_energy_mode_en,
  output logic ident_regs_lock
);
  import bridge_setup_pkg::*;

  // byte lane that carries a given bit
  function automatic logic lane(input logic [3:0] be, input int pos);
    lane = be[pos/8];
  endfunction : lane

  logic hit_rd, hit_wr, settle_done;
  assign hit_rd = cfg_rd && (cfg_addr == `SETUP_OFS);
  assign hit_wr = cfg_wr && (cfg_addr == `SETUP_OFS);

  // control and status flops
  logic drive_low_r, drive_low_nxt;
  sock_vec_t guard_dis_r, guard_dis_nxt;
  logic [4:0] rsvd_r, rsvd_nxt;
  logic burst_dn_r, burst_dn_nxt, burst_up_r, burst_up_nxt;
  sock_vec_t seen_r, seen_nxt;
  logic low_energy_r, low_energy_nxt, id_lock_r, id_lock_nxt;
  logic up_r, up_nxt, dn_r, dn_nxt, dir_up_r, dir_up_nxt;
  sock_vec_t probe_r, probe_nxt;
  stream_state_t st_r, st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic pme_clr;
  logic timer_start;
  logic [`SETTLE_W-1:0] timer_load;

  // bus reset reaches power-event context only while power events are off
  assign pme_clr = !bus_reset_n && !pme_en; // [RULE_16]

  // register writes, sticky flags and the power stream sequence
  always_comb begin
    drive_low_nxt = drive_low_r;
    guard_dis_nxt = guard_dis_r;
    rsvd_nxt = rsvd_r;
    burst_dn_nxt = burst_dn_r;
    burst_up_nxt = burst_up_r;
    low_energy_nxt = low_energy_r;
    id_lock_nxt = id_lock_r;
    seen_nxt = seen_r;
    st_nxt = st_r;
    up_nxt = up_r;
    dn_nxt = dn_r;
    dir_up_nxt = dir_up_r;
    timer_start = 1'b0;
    timer_load = '0;
    if (hit_wr) begin
      if (lane(cfg_be, `BIT_DRIVE_LOW)) begin
        drive_low_nxt = cfg_wdata[`BIT_DRIVE_LOW]; // [RULE_01]
        guard_dis_nxt[cfg_func] = cfg_wdata[`BIT_GUARD_DIS]; // [RULE_02]
        rsvd_nxt = cfg_wdata[`BIT_RSVD_HI:`BIT_RSVD_LO]; // stored as written [RULE_03]
      end
      // shared bits 15, 14, 6 and 5 only take writes through function 0
      if (!cfg_func && lane(cfg_be, `BIT_BURST_DN)) begin // [RULE_17]
        burst_dn_nxt = cfg_wdata[`BIT_BURST_DN]; // [RULE_04]
        burst_up_nxt = cfg_wdata[`BIT_BURST_UP]; // [RULE_05]
      end
      if (!cfg_func && lane(cfg_be, `BIT_LOW_ENERGY)) begin // [RULE_17]
        low_energy_nxt = cfg_wdata[`BIT_LOW_ENERGY]; // [RULE_13]
        id_lock_nxt = cfg_wdata[`BIT_ID_LOCK]; // [RULE_14]
      end
    end
    // read clears the reading function's flag; a same-cycle access wins
    if (hit_rd && lane(cfg_be, `BIT_SEEN)) begin
      seen_nxt[cfg_func] = 1'b0; // [RULE_06]
    end
    seen_nxt = seen_nxt | socket_access; // [RULE_06]
    // power stream: shift, then settle, busy throughout
    case (st_r)
      ST_IDLE: begin
        st_nxt = ST_IDLE;
      end
      ST_SHIFT: begin
        if (stream_shift_done) begin
          st_nxt = ST_SETTLE; // [RULE_08]
          up_nxt = dir_up_r; // [RULE_09]
          dn_nxt = !dir_up_r; // [RULE_10]
          timer_start = 1'b1;
          timer_load = dir_up_r ? `SETTLE_W'(SETTLE_UP) : `SETTLE_W'(SETTLE_DN);
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          st_nxt = ST_IDLE; // [RULE_08]
          up_nxt = 1'b0; // [RULE_09]
          dn_nxt = 1'b0; // [RULE_10]
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // a new request restarts the stream from the top
    if (pwr_change_req) begin
      st_nxt = ST_SHIFT; // [RULE_08]
      dir_up_nxt = pwr_up;
    end
    if (pme_clr) begin
      up_nxt = 1'b0; // [RULE_16]
      dn_nxt = 1'b0; // [RULE_16]
    end
  end

  // interrogation status follows the probe engine
  always_comb begin
    probe_nxt = pme_clr ? 2'h0 : probe_active; // [RULE_11] [RULE_16]
  end

  // read data, per function for socket-dependent bits
  always_comb begin
    rdata_nxt = rdata_r;
    if (hit_rd) begin
      rdata_nxt = 32'h0000_0000;
      rdata_nxt[`BIT_DRIVE_LOW] = drive_low_r;
      rdata_nxt[`BIT_GUARD_DIS] = guard_dis_r[cfg_func];
      rdata_nxt[`BIT_RSVD_HI:`BIT_RSVD_LO] = rsvd_r;
      rdata_nxt[`BIT_BURST_DN] = burst_dn_r;
      rdata_nxt[`BIT_BURST_UP] = burst_up_r;
      rdata_nxt[`BIT_SEEN] = seen_r[cfg_func]; // [RULE_06]
      rdata_nxt[`BIT_ONE] = 1'b1; // [RULE_07]
      rdata_nxt[`BIT_STREAM] = (st_r != ST_IDLE); // [RULE_08]
      rdata_nxt[`BIT_UP_SETTLE] = up_r;
      rdata_nxt[`BIT_DN_SETTLE] = dn_r;
      rdata_nxt[`BIT_PROBE] = probe_r[cfg_func]; // [RULE_11]
      rdata_nxt[`BIT_ZERO] = 1'b0; // [RULE_12]
      rdata_nxt[`BIT_LOW_ENERGY] = low_energy_r;
      rdata_nxt[`BIT_ID_LOCK] = id_lock_r;
    end
  end

  // global-only bits ignore the bus reset entirely
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drive_low_r <= `RST_DRIVE_LOW; // [RULE_15]
      guard_dis_r <= {2{`RST_GUARD_DIS}};
      rsvd_r <= `RST_RSVD;
      burst_dn_r <= `RST_BURST_DN;
      burst_up_r <= `RST_BURST_UP;
      low_energy_r <= `RST_LOW_ENERGY;
      id_lock_r <= `RST_ID_LOCK;
      seen_r <= 2'h0;
      st_r <= ST_IDLE;
      dir_up_r <= 1'b0;
      up_r <= 1'b0;
      dn_r <= 1'b0;
      probe_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      drive_low_r <= drive_low_nxt;
      guard_dis_r <= guard_dis_nxt;
      rsvd_r <= rsvd_nxt;
      burst_dn_r <= burst_dn_nxt;
      burst_up_r <= burst_up_nxt;
      low_energy_r <= low_energy_nxt;
      id_lock_r <= id_lock_nxt;
      seen_r <= seen_nxt;
      st_r <= st_nxt;
      dir_up_r <= dir_up_nxt;
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      probe_r <= probe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  settle_timer #(
    .W(`SETTLE_W)
  ) u_settle (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(timer_start),
    .load(timer_load),
    .done(settle_done)
  );

  // per socket: card detect synchroniser and reserved pin drive
  sock_vec_t card_in_r;
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      logic [2:0] sync_r, sync_nxt;
      logic in_nxt, oe_r, oe_nxt;
      // a change counts only once the last two stages agree
      always_comb begin
        sync_nxt = {sync_r[1:0], card_present[s]};
        in_nxt = (sync_r[2] == sync_r[1]) ? sync_r[2] : card_in_r[s];
        oe_nxt = drive_low_r && card_in_r[s]; // [RULE_01]
      end
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          sync_r <= 3'h0;
          card_in_r[s] <= 1'b0;
          oe_r <= 1'b0;
        end else begin
          sync_r <= sync_nxt;
          card_in_r[s] <= in_nxt;
          oe_r <= oe_nxt;
        end
      end
      assign rsvd_pin_oe[s] = oe_r;
      assign rsvd_pin_out[s] = 1'b0; // only ever drives low
    end
  endgenerate

  assign cfg_rdata = rdata_r;
  assign supply_guard_disable = guard_dis_r;
  assign read_burst_down_en = burst_dn_r;
  assign read_burst_up_en = burst_up_r;
  assign low_energy_mode_en = low_energy_r;
  assign ident_regs_lock = id_lock_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_pin_drive: assert property ((drive_low_r && card_in_r[1]) |=> rsvd_pin_oe[1]) // [RULE_01]
    else $error("reserved pins not driven");
  a_fixed_bits: assert property (hit_rd |=> cfg_rdata[12] && !cfg_rdata[7]) // [RULE_07] [RULE_12]
    else $error("fixed bits read wrong");
  a_seen_set: assert property (socket_access[1] |=> seen_r[1]) // [RULE_06]
    else $error("access flag lost");
  a_seen_clear: assert property ((hit_rd && !cfg_func && cfg_be[1] && !socket_access[0])
    |=> !seen_r[0]) // [RULE_06]
    else $error("access flag not cleared by read");
  a_stream_busy: assert property (pwr_change_req |=> st_r == ST_SHIFT) // [RULE_08]
    else $error("stream not busy after request");
  a_up_settle: assert property ((st_r == ST_SHIFT && stream_shift_done && dir_up_r
    && !pwr_change_req && !pme_clr) |=> up_r && !dn_r ##1 up_r) // [RULE_09]
    else $error("power-up settle flag wrong");
  a_settle_end: assert property ((st_r == ST_SETTLE && settle_done && !pwr_change_req)
    |=> st_r == ST_IDLE && !up_r && !dn_r) // [RULE_10]
    else $error("settle did not end");
  a_lock_write: assert property ((hit_wr && !cfg_func && cfg_be[0])
    |=> id_lock_r == $past(cfg_wdata[5])) // [RULE_14]
    else $error("lock bit not written");
  a_func1_shared: assert property ((hit_wr && cfg_func)
    |=> $stable(id_lock_r) && $stable(burst_dn_r) && $stable(low_energy_r)) // [RULE_17]
    else $error("shared bit written from function 1");
  a_bus_rst_keep: assert property ((!bus_reset_n && !hit_wr)
    |=> $stable(drive_low_r) && $stable(burst_up_r) && $stable(guard_dis_r)) // [RULE_15]
    else $error("bus reset touched global bit");
  a_pme_clear: assert property (pme_clr |=> probe_r == 2'h0 && !up_r) // [RULE_16]
    else $error("context bits survived bus reset");
endmodule : bridge_system_setup

// ==== core/bridge_setup_map.svh ====
// Behaviour
// RULE_01: with bit 22 set and a card-bus card present, the socket's reserved pins are driven low; otherwise they float; resets to 1.
// RULE_02: bit 21, per socket, disables 16-bit card supply protection when 1 and enables it when 0; resets to 0.
// RULE_03: software writes bits 20 to 16 back unchanged; the device just stores them.
// RULE_04: bit 15 set lets downstream memory reads burst; resets to 1.
// RULE_05: bit 14 set lets upstream memory reads burst; resets to 0.
// RULE_06: bit 13, per socket, is set by any card access and cleared by a read of the register.
// RULE_07: bit 12 always reads 1.
// RULE_08: bit 11 is 1 from a power change request until the switch stream and its settle delay end.
// RULE_09: bit 10 is set when a power-up stream has been sent and clears when the power-up delay expires.
// RULE_10: bit 9 is set when a power-down stream has been sent and clears when the power-down delay expires.
// RULE_11: bit 8, per socket, is 1 while a card interrogation runs.
// RULE_12: bit 7 always reads 0.
// RULE_13: bit 6 enables the low energy mode, is shared by both functions, and resets to 1.
// RULE_14: bit 5 at 1 (reset) locks the identity registers read-only; at 0 they are writable.
// RULE_15: bits 22, 21, 15, 14, 13, 11, 6 and 5 are cleared by the global reset only.
// RULE_16: bits 10, 9 and 8 are cleared by the bus reset only while power events are disabled; always by the global reset.
// RULE_17: software reaches bits 15, 14, 6 and 5 only through function 0.
`ifndef BRIDGE_SETUP_MAP_SVH
`define BRIDGE_SETUP_MAP_SVH

`define SETUP_OFS 8'h80
`define BIT_DRIVE_LOW 22
`define BIT_GUARD_DIS 21
`define BIT_RSVD_LO 16
`define BIT_RSVD_HI 20
`define BIT_BURST_DN 15
`define BIT_BURST_UP 14
`define BIT_SEEN 13
`define BIT_ONE 12
`define BIT_STREAM 11
`define BIT_UP_SETTLE 10
`define BIT_DN_SETTLE 9
`define BIT_PROBE 8
`define BIT_ZERO 7
`define BIT_LOW_ENERGY 6
`define BIT_ID_LOCK 5
`define RST_DRIVE_LOW 1'b1
`define RST_GUARD_DIS 1'b0
`define RST_RSVD 5'h00
`define RST_BURST_DN 1'b1
`define RST_BURST_UP 1'b0
`define RST_LOW_ENERGY 1'b1
`define RST_ID_LOCK 1'b1
`define SETTLE_UP_CYC 16
`define SETTLE_DN_CYC 16
`define SETTLE_W 16

`endif

// ==== core/bridge_setup_pkg.sv ====
package bridge_setup_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_SETTLE = 2'b10
  } stream_state_t;
  typedef logic [1:0] sock_vec_t;
endpackage : bridge_setup_pkg

// ==== core/settle_timer.sv ====
`timescale 1ns/1ps
// one-shot down counter: done pulses LOAD+1 cycles after the cycle that raises start
module settle_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  // a restart simply reloads, so the latest request sets the delay
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = load;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule : settle_timer

// ==== dv/socket_partner.sv ====
`timescale 1ns/1ps
// power switch stand-in: shifts a stream after each request, fast or slow
module socket_partner #(
  parameter int SLOW_CYC = 9
) (
  // clock
  input wire logic core_clk,
  // request side
  input wire logic pwr_change_req,
  input wire logic slow,
  // answer
  output logic stream_shift_done
);
  int cnt_r = 0;
  initial stream_shift_done = 1'b0;
  // a new request restarts the stream; done is a one-cycle pulse, never held
  always @(posedge core_clk) begin
    stream_shift_done <= (cnt_r == 1);
    if (pwr_change_req) cnt_r <= slow ? SLOW_CYC : 4;
    else if (cnt_r != 0) cnt_r <= cnt_r - 1;
  end
endmodule : socket_partner

// ==== dv/bridge_system_setup_bench.sv ====
`timescale 1ns/1ps
`include "bridge_setup_map.svh"
module bridge_system_setup_bench;
  import bridge_setup_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_reset_n = 1'b1;
  logic pme_en = 1'b0;
  logic cfg_func = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = `SETUP_OFS;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  sock_vec_t card_present = 2'h0;
  sock_vec_t socket_access = 2'h0;
  sock_vec_t probe_active = 2'h0;
  sock_vec_t rsvd_pin_out, rsvd_pin_oe, supply_guard_disable;
  logic pwr_change_req = 1'b0;
  logic pwr_up = 1'b0;
  logic slow = 1'b0;
  logic stream_shift_done;
  logic read_burst_down_en, read_burst_up_en, low_energy_mode_en, ident_regs_lock;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic rd_seen = 1'b0;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [31:0] wa, wb;

  bridge_system_setup #(.SETTLE_UP(8), .SETTLE_DN(4)) uut (.core_clk, .rstn, .bus_reset_n,
    .pme_en, .cfg_func, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .card_present, .socket_access, .probe_active, .rsvd_pin_out, .rsvd_pin_oe,
    .pwr_change_req, .pwr_up, .stream_shift_done, .supply_guard_disable,
    .read_burst_down_en, .read_burst_up_en, .low_energy_mode_en, .ident_regs_lock);
  socket_partner #(.SLOW_CYC(9)) partner (.core_clk, .pwr_change_req, .slow,
    .stream_shift_done);

  always #50 core_clk = ~core_clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic f, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_func <= f;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask : wr

  // the expected value is noted when the read is issued, judged when data lands
  task automatic rd(input logic f, input logic [31:0] exp, input logic [31:0] m);
    @(posedge core_clk);
    cfg_func <= f;
    cfg_addr <= `SETUP_OFS;
    cfg_rd <= 1'b1;
    notes.push_back({exp & m, m});
    @(posedge core_clk);
    cfg_rd <= 1'b0;
  endtask : rd

  // hit reads update cfg_rdata one edge later; a hang ends the run as a failure
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    rd_seen <= cfg_rd && cfg_addr == `SETUP_OFS;
    if (cycles == 4000) begin
      failures++;
      test_done();
    end
  end

  always @(negedge core_clk) begin
    if (rd_seen) begin
      note = notes.pop_front();
      chk("cfg_rdata", cfg_rdata & note[31:0], note[63:32]);
    end
  end

  initial begin
    wa = $urandom(89);
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rd(1'b0, 32'h00409060, 32'hffffffff);
    chk("ctl", {supply_guard_disable, read_burst_down_en, read_burst_up_en,
      low_energy_mode_en, ident_regs_lock}, 32'h0b);
    // reserved bits 20:16 are written back as read, zero here
    wa = $urandom & 32'hffe0ffff;
    wb = $urandom & 32'hffe0ffff;
    wr(1'b0, `SETUP_OFS, wa);
    wr(1'b1, `SETUP_OFS, wb);
    wr(1'b0, 8'h84, ~wa);
    rd(1'b0, (wb & 32'h00400000) | (wa & 32'h0020c060) | 32'h1000, 32'hffffffff);
    rd(1'b1, (wb & 32'h00600000) | (wa & 32'h0000c060) | 32'h1000, 32'hffffffff);
    chk("ctl", {supply_guard_disable, read_burst_down_en, read_burst_up_en, low_energy_mode_en,
      ident_regs_lock}, {wb[21], wa[21], wa[15], wa[14], wa[6], wa[5]});
    // low byte lane only: bits 6 and 5 move, the upper lanes hold
    cfg_be <= 4'h1;
    wr(1'b0, `SETUP_OFS, ~wa & 32'hffe0ffff);
    cfg_be <= 4'hf;
    wa[6:5] = ~wa[6:5];
    rd(1'b0, (wb & 32'h00400000) | (wa & 32'h0020c060) | 32'h1000, 32'hffffffff);
    // reserved pins follow bit 22 only on a socket holding a card
    card_present <= 2'h2;
    wa[22] = 1'b1;
    wr(1'b0, `SETUP_OFS, wa);
    repeat (8) @(posedge core_clk);
    chk("pin_oe", {rsvd_pin_oe, rsvd_pin_out}, 32'h8);
    wa[22] = 1'b0;
    wr(1'b0, `SETUP_OFS, wa);
    repeat (2) @(posedge core_clk);
    chk("pin_oe", rsvd_pin_oe, 32'h0);
    @(posedge core_clk);
    socket_access <= 2'h3;
    @(posedge core_clk);
    socket_access <= 2'h0;
    rd(1'b1, 32'h2000, 32'h2000);
    rd(1'b0, 32'h2000, 32'h2000);
    rd(1'b0, 32'h0, 32'h2000);
    // power down with a fast switch, then power up with a slow one
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      pwr_change_req <= 1'b1;
      pwr_up <= i[0];
      slow <= i[0];
      @(posedge core_clk);
      pwr_change_req <= 1'b0;
      rd(1'b0, 32'h800, 32'he00);
      n = 0;
      while (!stream_shift_done && n < 30) begin
        @(negedge core_clk);
        n++;
      end
      rd(1'b0, i[0] ? 32'hc00 : 32'ha00, 32'he00);
      repeat (12) @(posedge core_clk);
      rd(1'b0, 32'h0, 32'he00);
    end
    // with power events off, a bus reset drops the settle flag mid-delay
    @(posedge core_clk);
    pwr_change_req <= 1'b1;
    pwr_up <= 1'b1;
    slow <= 1'b0;
    @(posedge core_clk);
    pwr_change_req <= 1'b0;
    n = 0;
    while (!stream_shift_done && n < 30) begin
      @(negedge core_clk);
      n++;
    end
    repeat (2) @(posedge core_clk);
    bus_reset_n <= 1'b0;
    @(posedge core_clk);
    bus_reset_n <= 1'b1;
    rd(1'b0, 32'h800, 32'he00);
    repeat (12) @(posedge core_clk);
    // with power events on, a bus reset leaves global and context bits alone
    @(posedge core_clk);
    pme_en <= 1'b1;
    probe_active <= 2'h1;
    @(posedge core_clk);
    bus_reset_n <= 1'b0;
    @(posedge core_clk);
    bus_reset_n <= 1'b1;
    rd(1'b0, (wa & 32'h007fc060) | 32'h1100, 32'hffffffff);
    @(posedge core_clk);
    probe_active <= 2'h0;
    repeat (2) @(posedge core_clk);
    rd(1'b0, 32'h0, 32'h100);
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule : bridge_system_setup_bench
